// ==== core/nv_store.sv ====
// nonvolatile value store with timed programming cycle
`timescale 1ns/1ps
`default_nettype none

module nv_store
  import quad_dac_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = NV_PROG_CYCLES
) (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              srst_i,
  // program request
  input  wire logic              start_i,
  input  wire logic [CHAN_W-1:0] chan_i,
  input  wire logic [7:0]        value_i,
  // status and contents
  output var  logic              done_o,
  output var  chan_bank_t        nv_bank_o
);

  localparam int unsigned CNT_W = $clog2(PROG_CYCLES + 1);

  // survives srst_i; only a programming cycle changes it
  logic [DATA_BITS-1:0] nv_mem [NUM_CHAN] = '{default: NV_INIT_VALUE};
  logic [CNT_W-1:0]     cnt_reg;
  logic                 busy_reg;
  logic [CHAN_W-1:0]    chan_reg;
  logic [7:0]           value_reg;
  wire                  last_cycle = busy_reg && (cnt_reg == CNT_W'(PROG_CYCLES - 1));

  if (PROG_CYCLES < 1) begin : g_bad_cycles
    $error("nv_store needs at least one programming cycle");
  end

  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_bank
    assign nv_bank_o[g] = nv_mem[g];
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      busy_reg  <= 1'b0;
      cnt_reg   <= '0;
      chan_reg  <= '0;
      value_reg <= '0;
      done_o    <= 1'b0;
    end else begin
      done_o <= last_cycle;
      if (start_i && !busy_reg) begin
        busy_reg  <= 1'b1;
        cnt_reg   <= '0;
        chan_reg  <= chan_i;
        value_reg <= value_i;
      end else if (last_cycle) begin
        busy_reg <= 1'b0;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (last_cycle) begin
      nv_mem[chan_reg] <= value_reg;
    end
  end

endmodule : nv_store

`default_nettype wire

// ==== core/pin_sync.sv ====
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int unsigned             WIDTH     = 4,
  parameter logic [WIDTH-1:0]        RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             srst_i,
  // pins
  input  wire logic [WIDTH-1:0] pin_i,
  output var  logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs at least one bit");
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      meta_reg <= RESET_VAL;
      sync_o   <= RESET_VAL;
    end else begin
      meta_reg <= pin_i;
      sync_o   <= meta_reg;
    end
  end

endmodule : pin_sync

`default_nettype wire

// ==== core/quad_dac_pkg.sv ====
// shared constants and types for the quad dac serial command port
package quad_dac_pkg;

  // channel and frame geometry
  localparam int unsigned NUM_CHAN   = 4;
  localparam int unsigned CHAN_W     = 2;
  localparam int unsigned DATA_BITS  = 8;
  localparam int unsigned HDR_BITS   = 4;
  localparam int unsigned BIT_CNT_W  = 4;

  // command codes
  localparam logic [1:0] CMD_PERSIST_UNLOCK = 2'h0;
  localparam logic [1:0] CMD_WRITE          = 2'h1;
  localparam logic [1:0] CMD_READ           = 2'h2;
  localparam logic [1:0] CMD_RECALL         = 2'h3;

  // start bit value
  localparam logic START_BIT = 1'b1;

  // pin reset values (idle levels)
  localparam logic [3:0] PIN_SYNC_RESET = 4'h2;

  // timing
  localparam int unsigned CLK_FREQ_KHZ       = 40000;
  localparam int unsigned NV_PROG_TIME_US    = 5000;
  localparam int unsigned NV_PROG_CYCLES     = (NV_PROG_TIME_US * CLK_FREQ_KHZ) / 1000;
  localparam logic [1:0]  STRAP_SETTLE_LAST  = 2'h3;

  // nonvolatile contents before any programming
  localparam logic [7:0] NV_INIT_VALUE = 8'h00;

  // per-channel value bank
  typedef logic [NUM_CHAN-1:0][DATA_BITS-1:0] chan_bank_t;

  // decoded frame header: command then channel, msb first on the wire
  typedef struct packed {
    logic [1:0]        cmd;
    logic [CHAN_W-1:0] chan;
  } frame_hdr_t;

  // serial front-end states, gray along the path from powerup to done
  typedef enum logic [2:0] {
    ST_POWERUP = 3'h0,
    ST_IDLE    = 3'h1,
    ST_HEADER  = 3'h3,
    ST_DATA    = 3'h2,
    ST_DONE    = 3'h6,
    ST_BUSY    = 3'h7
  } port_state_t;

endpackage : quad_dac_pkg

// ==== core/quad_dac_serial_command_port.sv ====
// serial command port and channel registers of a quad 8-bit dac
//
// Functional notes
// - input bits taken on serial clock rise, output bits changed on fall.
// - every multi-bit field travels most significant bit first.
// - serial output driven only after a complete valid read header.
// - a frame starts only with select low and a one start bit.
// - start bit, two command bits, two channel bits, then eight data clocks.
// - command 00 unlock, 01 write, 10 read, 11 recall.
// - four channels, each an independent 8-bit value.
// - each channel has a volatile value and a stored default.
// - read shifts the channel value out, changing no channel or stored value.
// - write updates the channel value as the eighth data bit arrives.
// - after the last write bit a new frame with start bit is needed.
// - ordinary write leaves the stored default unchanged.
// - persistent write is two steps; unlock frame data bits are ignored.
// - read or recall after unlock clears the unlock.
// - unlocked write loads the value, programming starts when select rises.
// - ready/busy pulled low during programming, released after.
// - select high deselects, ignores the bus, low-power state.
// - at power-up with option low channel values reload from defaults unasked.
// - recall copies the stored default into the channel value.
// - power-up loads defaults with option low, zeroes with option high.
`timescale 1ns/1ps
`default_nettype none

module quad_dac_serial_command_port
  import quad_dac_pkg::*;
#(
  parameter int unsigned NV_PROG_CYC = NV_PROG_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  // serial pins
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic serial_in_i,
  output var  logic serial_out_o,
  output var  logic serial_out_oe_o,
  // ready/busy open drain
  output var  logic nv_program_idle_n_o,
  output var  logic nv_program_idle_n_oe_o,
  // power-up option strap
  input  wire logic recall_zero_i,
  // channel values and power state
  output var  chan_bank_t dac_value_o,
  output var  logic       low_power_o
);

  if (NV_PROG_CYC < 1) begin : g_bad_prog
    $error("programming time must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [3:0] pins_s;
  wire        sclk_s      = pins_s[0];
  wire        cs_n_s      = pins_s[1];
  wire        sin_s       = pins_s[2];
  wire        strap_s     = pins_s[3];

  pin_sync #(
    .WIDTH     (4),
    .RESET_VAL (PIN_SYNC_RESET)
  ) u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .pin_i     ({recall_zero_i, serial_in_i, cs_n_i, sclk_i}),
    .sync_o    (pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers

  port_state_t              state_reg,    state_next;
  logic [BIT_CNT_W-1:0]     bit_cnt_reg,  bit_cnt_next;
  logic [2:0]               hdr_sr_reg,   hdr_sr_next;
  frame_hdr_t               hdr_reg,      hdr_next;
  logic [DATA_BITS-1:0]     din_sr_reg,   din_sr_next;
  logic [DATA_BITS-1:0]     dout_sr_reg,  dout_sr_next;
  logic                     sout_reg,     sout_next;
  logic                     sout_oe_reg,  sout_oe_next;
  logic                     unlock_reg,   unlock_next;
  logic                     nv_pend_reg,  nv_pend_next;
  logic [CHAN_W-1:0]        nv_chan_reg,  nv_chan_next;
  logic [DATA_BITS-1:0]     nv_val_reg,   nv_val_next;
  chan_bank_t               data_reg,     data_next;
  logic [1:0]               pwr_cnt_reg,  pwr_cnt_next;
  logic                     prog_oe_reg;
  logic                     low_power_reg;
  logic                     sclk_prev_reg;
  logic                     start_prog;

  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile store

  chan_bank_t nv_bank;
  logic       nv_done;

  nv_store #(
    .PROG_CYCLES (NV_PROG_CYC)
  ) u_nv_store (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .start_i   (start_prog),
    .chan_i    (nv_chan_reg),
    .value_i   (nv_val_reg),
    .done_o    (nv_done),
    .nv_bank_o (nv_bank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire        selected    = !cs_n_s;
  wire        sclk_rise   = selected && sclk_s && !sclk_prev_reg;
  wire        sclk_fall   = selected && !sclk_s && sclk_prev_reg;
  wire [3:0]  hdr_bits    = {hdr_sr_reg, sin_s};
  frame_hdr_t hdr_full;
  assign      hdr_full    = frame_hdr_t'(hdr_bits);
  wire        hdr_last    = bit_cnt_reg == BIT_CNT_W'(HDR_BITS - 1);
  wire        data_last   = bit_cnt_reg == BIT_CNT_W'(DATA_BITS - 1);
  wire        is_write    = hdr_reg.cmd == CMD_WRITE;
  wire        is_read     = hdr_reg.cmd == CMD_READ;
  wire [7:0]  din_full    = {din_sr_reg[DATA_BITS-2:0], sin_s};
  wire        in_frame    = state_reg inside {ST_IDLE, ST_HEADER, ST_DATA, ST_DONE};
  wire        pwr_ready   = pwr_cnt_reg == STRAP_SETTLE_LAST;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg;
    hdr_sr_next  = hdr_sr_reg;
    hdr_next     = hdr_reg;
    din_sr_next  = din_sr_reg;
    dout_sr_next = dout_sr_reg;
    sout_next    = sout_reg;
    sout_oe_next = sout_oe_reg;
    unlock_next  = unlock_reg;
    nv_pend_next = nv_pend_reg;
    nv_chan_next = nv_chan_reg;
    nv_val_next  = nv_val_reg;
    data_next    = data_reg;
    pwr_cnt_next = pwr_cnt_reg;
    start_prog   = 1'b0;

    unique case (state_reg)
      ST_POWERUP: begin
        pwr_cnt_next = pwr_cnt_reg + 2'h1;
        if (pwr_ready) begin
          data_next  = strap_s ? '0 : nv_bank;
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (sclk_rise && sin_s == START_BIT) begin
          state_next   = ST_HEADER;
          bit_cnt_next = '0;
        end
      end
      ST_HEADER: begin
        if (sclk_rise) begin
          hdr_sr_next  = hdr_bits[2:0];
          bit_cnt_next = bit_cnt_reg + 1'b1;
          if (hdr_last) begin
            hdr_next     = hdr_full;
            bit_cnt_next = '0;
            din_sr_next  = '0;
            state_next   = ST_DATA;
            unique case (hdr_full.cmd)
              CMD_PERSIST_UNLOCK: unlock_next = 1'b1;
              CMD_WRITE:          unlock_next = unlock_reg;
              CMD_READ: begin
                unlock_next  = 1'b0;
                dout_sr_next = data_reg[hdr_full.chan];
              end
              CMD_RECALL: begin
                unlock_next = 1'b0;
                data_next[hdr_full.chan] = nv_bank[hdr_full.chan];
              end
            endcase
          end
        end
      end
      ST_DATA: begin
        if (sclk_rise) begin
          bit_cnt_next = bit_cnt_reg + 1'b1;
          if (is_write) begin
            din_sr_next = din_full;
          end
          if (data_last) begin
            state_next = ST_DONE;
            if (is_write) begin
              data_next[hdr_reg.chan] = din_full;
              if (unlock_reg) begin
                nv_pend_next = 1'b1;
                nv_chan_next = hdr_reg.chan;
                nv_val_next  = din_full;
                unlock_next  = 1'b0;
              end
            end
          end
        end
        if (sclk_fall && is_read) begin
          sout_next    = dout_sr_reg[DATA_BITS-1];
          dout_sr_next = {dout_sr_reg[DATA_BITS-2:0], 1'b0};
          sout_oe_next = 1'b1;
        end
      end
      ST_DONE: begin
        if (sclk_fall) begin
          sout_oe_next = 1'b0;
        end
      end
      ST_BUSY: begin
        if (nv_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase

    if (in_frame && cs_n_s) begin
      state_next   = nv_pend_reg ? ST_BUSY : ST_IDLE;
      bit_cnt_next = '0;
      sout_oe_next = 1'b0;
      if (nv_pend_reg) begin
        start_prog   = 1'b1;
        nv_pend_next = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state flops

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_reg   <= ST_POWERUP;
      bit_cnt_reg <= '0;
      hdr_sr_reg  <= '0;
      hdr_reg     <= '0;
      din_sr_reg  <= '0;
      dout_sr_reg <= '0;
      unlock_reg  <= 1'b0;
      nv_pend_reg <= 1'b0;
      nv_chan_reg <= '0;
      nv_val_reg  <= '0;
      pwr_cnt_reg <= '0;
    end else begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      hdr_sr_reg  <= hdr_sr_next;
      hdr_reg     <= hdr_next;
      din_sr_reg  <= din_sr_next;
      dout_sr_reg <= dout_sr_next;
      unlock_reg  <= unlock_next;
      nv_pend_reg <= nv_pend_next;
      nv_chan_reg <= nv_chan_next;
      nv_val_reg  <= nv_val_next;
      pwr_cnt_reg <= pwr_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output flops

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      data_reg      <= '0;
      sout_reg      <= 1'b0;
      sout_oe_reg   <= 1'b0;
      prog_oe_reg   <= 1'b0;
      low_power_reg <= 1'b1;
      sclk_prev_reg <= 1'b0;
    end else begin
      data_reg      <= data_next;
      sout_reg      <= sout_next;
      sout_oe_reg   <= sout_oe_next;
      prog_oe_reg   <= state_next == ST_BUSY;
      low_power_reg <= cs_n_s;
      sclk_prev_reg <= sclk_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign dac_value_o            = data_reg;
  assign serial_out_o           = sout_reg;
  assign serial_out_oe_o        = sout_oe_reg;
  assign nv_program_idle_n_o    = 1'b0;
  assign nv_program_idle_n_oe_o = prog_oe_reg;
  assign low_power_o            = low_power_reg;

endmodule : quad_dac_serial_command_port

`default_nettype wire

// ==== dv/quad_dac_port_properties.sv ====
// assertion checker bound to the quad dac serial command port
`timescale 1ns/1ps
`default_nettype none

module quad_dac_port_checker
  import quad_dac_pkg::*;
#(
  parameter int unsigned NV_PROG_CYC = NV_PROG_CYCLES
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  // serial pins
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       serial_in_i,
  input  wire logic       serial_out_o,
  input  wire logic       serial_out_oe_o,
  // ready/busy
  input  wire logic       nv_program_idle_n_o,
  input  wire logic       nv_program_idle_n_oe_o,
  // strap, values, power
  input  wire logic       recall_zero_i,
  input  wire chan_bank_t dac_value_o,
  input  wire logic       low_power_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // helper counters
  logic [4:0]  up_cnt_reg;
  logic [31:0] busy_cnt_reg;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      up_cnt_reg <= 5'h00;
    end else if (up_cnt_reg != 5'h1f) begin
      up_cnt_reg <= up_cnt_reg + 5'h01;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !nv_program_idle_n_oe_o) begin
      busy_cnt_reg <= 32'h0;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // properties
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  sequence desel_s;
    cs_n_i [*6];
  endsequence
  sequence sel_s;
    !cs_n_i [*6];
  endsequence

  oe_deselect_a: assert property (desel_s |-> !serial_out_oe_o)
    else $error("serial output driven while deselected");
  lp_deselect_a: assert property (desel_s |-> low_power_o)
    else $error("low power missing while deselected");
  lp_select_a: assert property (sel_s |-> !low_power_o)
    else $error("low power while selected");
  dac_hold_a: assert property (((up_cnt_reg == 5'h1f) and desel_s) |=> $stable(dac_value_o))
    else $error("channel value changed while deselected");
  busy_max_a: assert property (busy_cnt_reg <= NV_PROG_CYC + 32'd4)
    else $error("programming busy too long");
  busy_min_a: assert property ($fell(nv_program_idle_n_oe_o) |-> busy_cnt_reg + 32'd1 >= NV_PROG_CYC)
    else $error("programming busy too short");
  busy_start_a: assert property ($rose(nv_program_idle_n_oe_o) |-> cs_n_i && $past(cs_n_i, 2))
    else $error("programming started while selected");
  out_fall_a: assert property ($changed(serial_out_o) && $past(serial_out_oe_o) |-> !$past(sclk_i, 3))
    else $error("serial output changed off a falling edge");
  busy_quiet_a: assert property (nv_program_idle_n_oe_o |-> !serial_out_oe_o)
    else $error("serial output driven while busy");
  busy_pull_a: assert property (nv_program_idle_n_oe_o |-> !nv_program_idle_n_o)
    else $error("busy pin not pulled low");
endmodule // quad_dac_port_checker

bind quad_dac_serial_command_port quad_dac_port_checker #(.NV_PROG_CYC(NV_PROG_CYC)) i_chk (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .serial_in_i(serial_in_i), .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
  .nv_program_idle_n_o(nv_program_idle_n_o), .nv_program_idle_n_oe_o(nv_program_idle_n_oe_o),
  .recall_zero_i(recall_zero_i), .dac_value_o(dac_value_o), .low_power_o(low_power_o)
);

`default_nettype wire

// ==== dv/serial_host_model.sv ====
// host model driving the four-wire serial link
`timescale 1ns/1ps
`default_nettype none

module serial_host_model (
  // clock
  input  wire logic ref_clk_i,
  // serial pins
  output var  logic sclk_o,
  output var  logic cs_n_o,
  output var  logic sdi_o,
  input  wire logic sdo_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // half period of the 200 ns link clock
  task automatic half();
    repeat (4) @(posedge ref_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // one frame, first n bits of bits sent from the top
  task automatic frame(input logic [17:0] bits, input int n, input logic sel,
                       output logic [7:0] rd);
    rd = 8'h00;
    @(posedge ref_clk_i);
    cs_n_o <= ~sel;
    half();
    for (int i = 0; i < n; i++) begin
      sdi_o <= bits[17-i];
      half();
      sclk_o <= 1'b1;
      half();
      if (i >= 5 && i < 13) rd = {rd[6:0], sdo_i};
      sclk_o <= 1'b0;
    end
    half();
    cs_n_o <= 1'b1;
    sdi_o  <= ~sdi_o;
    repeat (8) @(posedge ref_clk_i);
  endtask
endmodule // serial_host_model

`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the quad dac serial command port
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end

module tb;
  import quad_dac_pkg::*;
  localparam int unsigned PROG_CYC = 20;
  logic       ref_clk_i;
  logic       srst_i;
  logic       recall_zero_i;
  wire logic  sclk, cs_n, sdi, sdo, sdo_oe, idle_n, idle_n_oe, low_power;
  wire chan_bank_t dac;
  wire logic  rdy_pin = idle_n_oe ? idle_n : 1'b1;
  // released data out reads as the inverse of the held bit
  wire logic  sdo_line = sdo_oe ? sdo : ~sdo;
  int         n_mismatch;
  int         num_checks;
  logic [7:0] rd;
  logic [7:0] vals [4] = '{8'h5a, 8'ha5, 8'h81, 8'h7e};

  quad_dac_serial_command_port #(.NV_PROG_CYC(PROG_CYC)) i_dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .serial_in_i(sdi), .serial_out_o(sdo), .serial_out_oe_o(sdo_oe),
    .nv_program_idle_n_o(idle_n), .nv_program_idle_n_oe_o(idle_n_oe),
    .recall_zero_i(recall_zero_i), .dac_value_o(dac), .low_power_o(low_power)
  );
  serial_host_model i_host (
    .ref_clk_i(ref_clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_line)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic rst(input logic z);
    @(posedge ref_clk_i);
    recall_zero_i <= z;
    srst_i        <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    repeat (20) @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [1:0] cmd, input logic [1:0] ch, input logic [7:0] v,
                    input int n);
    i_host.frame({START_BIT, cmd, ch, v, 5'h00}, n, 1'b1, rd);
  endtask
  task automatic wait_prog();
    int k;
    k = 0;
    while (rdy_pin !== 1'b0 && k < 40) begin
      @(posedge ref_clk_i);
      k++;
    end
    `CHK(rdy_pin, 1'b0)
    while (rdy_pin !== 1'b1 && k < 200) begin
      @(posedge ref_clk_i);
      k++;
    end
    if (rdy_pin !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t busy never ended", $time);
      end_of_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #1ms;
    n_mismatch++;
    $display("[ERR] %0t run timed out", $time);
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    srst_i        = 1'b1;
    recall_zero_i = 1'b0;
    n_mismatch    = 0;
    num_checks    = 0;
    rst(1'b0);
    for (int c = 0; c < 4; c++) `CHK(dac[c], NV_INIT_VALUE)
    for (int c = 0; c < 4; c++) wr(CMD_WRITE, c[1:0], vals[c], 13);
    for (int c = 0; c < 4; c++) `CHK(dac[c], vals[c])
    for (int c = 0; c < 4; c++) begin
      wr(CMD_READ, c[1:0], 8'hff, 13);
      `CHK(rd, vals[c])
      `CHK(dac[c], vals[c])
    end
    i_host.frame({START_BIT, CMD_WRITE, 2'h0, 8'h11, START_BIT, CMD_WRITE, 2'h1},
                 18, 1'b1, rd);
    `CHK(dac[0], 8'h11)
    `CHK(dac[1], vals[1])
    wr(CMD_WRITE, 2'h3, 8'h00, 9);
    `CHK(dac[3], vals[3])
    i_host.frame({START_BIT, CMD_WRITE, 2'h2, 8'h00, 5'h00}, 13, 1'b0, rd);
    `CHK(dac[2], vals[2])
    `CHK(low_power, 1'b1)
    wr(CMD_PERSIST_UNLOCK, 2'h1, 8'hff, 13);
    wr(CMD_READ, 2'h1, 8'h00, 13);
    wr(CMD_WRITE, 2'h1, 8'h3c, 13);
    `CHK(rdy_pin, 1'b1)
    `CHK(dac[1], 8'h3c)
    wr(CMD_PERSIST_UNLOCK, 2'h2, 8'h00, 5);
    wr(CMD_WRITE, 2'h2, 8'hc3, 13);
    wait_prog();
    `CHK(dac[2], 8'hc3)
    wr(CMD_WRITE, 2'h2, 8'h00, 13);
    `CHK(dac[2], 8'h00)
    wr(CMD_RECALL, 2'h2, 8'h00, 5);
    `CHK(dac[2], 8'hc3)
    rst(1'b1);
    for (int c = 0; c < 4; c++) `CHK(dac[c], 8'h00)
    rst(1'b0);
    `CHK(dac[2], 8'hc3)
    `CHK(dac[0], NV_INIT_VALUE)
    end_of_test();
  end
endmodule // tb

`default_nettype wire
